// *** src/ecsd_host.sv ***
// Link controller with AXI4-Lite register slave
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module ecsd_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Link to the bank
  ecsd_link_if.host        link
);
  import ecsd_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_WAIT = 3'b100
  } ecsd_hst_t;

  ecsd_hst_t   state_r;
  logic        awHeld_r, wHeld_r, awRdy_r, wRdy_r, bValid_r, arRdy_r, rValid_r;
  logic [7:0]  awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic [1:0]  bResp_r, rResp_r;
  logic [31:0] rData_r;
  logic [15:0] node_r, data_r, rsp_r;
  ecsd_op_t    op_r;
  logic [7:0]  index_r, wait_r;
  logic        done_r, noRsp_r, refused_r, drvOk_r;
  logic        doWrite, launch, refuse;

  assign doWrite = awHeld_r && wHeld_r && !bValid_r;
  assign launch  = doWrite && awAddr_r == OFF_CTRL && wStrb_r[0] && state_r == ST_IDLE;
  // Zero address never assigned; driver stage only if reported
  assign refuse  = (ecsd_op_t'(wData_r[2:0]) == ECSD_OP_SET_NODE && data_r == NODE_BROADCAST)
                || (ecsd_op_t'(wData_r[2:0]) == ECSD_OP_SET_DRV && !drvOk_r);

  // Write address and data capture, either order
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awRdy_r  <= 1'b0;
      wRdy_r   <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awRdy_r)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
        awRdy_r  <= 1'b0;
      end
      else if (doWrite)
        awHeld_r <= 1'b0;
      else if (!awHeld_r && !bValid_r)
        awRdy_r <= 1'b1;
      if (s_axi_wvalid && wRdy_r)
      begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wRdy_r  <= 1'b0;
      end
      else if (doWrite)
        wHeld_r <= 1'b0;
      else if (!wHeld_r && !bValid_r)
        wRdy_r <= 1'b1;
    end
  end

  // Write response and register stores
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bValid_r <= 1'b0;
      bResp_r  <= 2'h0;
      node_r   <= RST_NODE;
      data_r   <= 16'h0000;
    end
    else if (doWrite)
    begin
      bValid_r <= 1'b1;
      bResp_r  <= 2'h0;
      if (awAddr_r == OFF_NODE)
      begin
        if (wStrb_r[0]) node_r[7:0]  <= wData_r[7:0];
        if (wStrb_r[1]) node_r[15:8] <= wData_r[15:8];
      end
      else if (awAddr_r == OFF_DATA)
      begin
        if (wStrb_r[0]) data_r[7:0]  <= wData_r[7:0];
        if (wStrb_r[1]) data_r[15:8] <= wData_r[15:8];
      end
      else if (awAddr_r != OFF_CTRL)
        bResp_r <= 2'h2;
    end
    else if (bValid_r && s_axi_bready)
      bValid_r <= 1'b0;
  end

  // Read channel
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      arRdy_r  <= 1'b0;
      rValid_r <= 1'b0;
      rData_r  <= 32'h0000_0000;
      rResp_r  <= 2'h0;
    end
    else if (s_axi_arvalid && arRdy_r)
    begin
      arRdy_r  <= 1'b0;
      rValid_r <= 1'b1;
      rResp_r  <= 2'h0;
      if (s_axi_araddr == OFF_CTRL)
        rData_r <= {16'h0000, index_r, 5'h00, op_r};
      else if (s_axi_araddr == OFF_NODE)
        rData_r <= {16'h0000, node_r};
      else if (s_axi_araddr == OFF_DATA)
        rData_r <= {16'h0000, data_r};
      else if (s_axi_araddr == OFF_STATUS)
        rData_r <= {27'h0000000, drvOk_r, refused_r, noRsp_r, done_r, state_r != ST_IDLE};
      else if (s_axi_araddr == OFF_RDATA)
        rData_r <= {16'h0000, rsp_r};
      else
      begin
        rData_r <= 32'h0000_0000;
        rResp_r <= 2'h2;
      end
    end
    else if (rValid_r && s_axi_rready)
      rValid_r <= 1'b0;
    else if (!rValid_r)
      arRdy_r <= 1'b1;
  end

  // Command sequencer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r   <= ST_IDLE;
      op_r      <= ECSD_OP_SET_NODE;
      index_r   <= 8'h00;
      wait_r    <= 8'h00;
      rsp_r     <= 16'h0000;
      done_r    <= 1'b0;
      noRsp_r   <= 1'b0;
      refused_r <= 1'b0;
      drvOk_r   <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          if (launch)
          begin
            op_r      <= ecsd_op_t'(wData_r[2:0]);
            index_r   <= wData_r[15:8];
            done_r    <= refuse;
            noRsp_r   <= 1'b0;
            refused_r <= refuse;
            if (!refuse)
              state_r <= ST_SEND;
          end
        ST_SEND:
        begin
          wait_r  <= 8'h00;
          state_r <= ST_WAIT;
        end
        ST_WAIT:
          if (link.rspValid)
          begin
            rsp_r   <= link.rspData;
            done_r  <= 1'b1;
            state_r <= ST_IDLE;
            if (op_r == ECSD_OP_GET_CAPS)
              drvOk_r <= link.rspData[0];
          end
          else if (wait_r == RSP_TIMEOUT_CYC)
          begin
            done_r  <= 1'b1;
            noRsp_r <= 1'b1;
            state_r <= ST_IDLE;
          end
          else
            wait_r <= wait_r + 8'h01;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Link drive: commands carry the target node address
  assign link.cmdValid = state_r == ST_SEND;
  assign link.cmdOp    = op_r;
  assign link.cmdNode  = node_r;
  assign link.cmdIndex = index_r;
  assign link.cmdData  = data_r;

  // AXI outputs from flops
  assign s_axi_awready = awRdy_r;
  assign s_axi_wready  = wRdy_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = arRdy_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;

endmodule : ecsd_host

// *** src/ecsd_pkg.sv ***
// Shared constants for the configuration byte bank and its controller
package ecsd_pkg;

  // Link command codes
  typedef enum logic [2:0] {
    ECSD_OP_SET_NODE = 3'h0,
    ECSD_OP_SELECT   = 3'h1,
    ECSD_OP_READ     = 3'h2,
    ECSD_OP_WRITE    = 3'h3,
    ECSD_OP_SET_DRV  = 3'h4,
    ECSD_OP_GET_CAPS = 3'h5
  } ecsd_op_t;

  // Byte indices of the configuration array
  localparam logic [7:0] IDX_LO          = 8'h0F;
  localparam logic [7:0] IDX_HI          = 8'h3E;
  localparam logic [7:0] IDX_CMDQ        = 8'h0F;
  localparam logic [7:0] IDX_SEC_REMOVAL = 8'h10;
  localparam logic [7:0] IDX_PSA_EN      = 8'h11;
  localparam logic [7:0] IDX_MAX_PRELOAD = 8'h12;
  localparam logic [7:0] IDX_PRELOAD     = 8'h16;
  localparam logic [7:0] IDX_FFU_RESULT  = 8'h1A;
  localparam logic [7:0] IDX_MODE_OP     = 8'h1D;
  localparam logic [7:0] IDX_MODE_SEL    = 8'h1E;
  localparam logic [7:0] IDX_BARRIER     = 8'h1F;
  localparam logic [7:0] IDX_FLUSH       = 8'h20;
  localparam logic [7:0] IDX_CACHE       = 8'h21;
  localparam logic [7:0] IDX_SHUTDOWN    = 8'h22;
  localparam logic [7:0] IDX_PACK_FAIL   = 8'h23;
  localparam logic [7:0] IDX_PACK_RESULT = 8'h24;
  localparam logic [7:0] IDX_CONTEXT     = 8'h25;
  localparam logic [7:0] IDX_CONTEXT_END = 8'h33;
  localparam logic [7:0] IDX_EXT_PART    = 8'h34;
  localparam logic [7:0] IDX_EXC_FLAGS   = 8'h36;
  localparam logic [7:0] IDX_EXC_MASK    = 8'h38;
  localparam logic [7:0] IDX_GROUPS_REL  = 8'h3A;
  localparam logic [7:0] IDX_CLASS6      = 8'h3B;
  localparam logic [7:0] IDX_INIT_TMO    = 8'h3C;
  localparam logic [7:0] IDX_BLK_SIZE    = 8'h3D;
  localparam logic [7:0] IDX_EMULATION   = 8'h3E;

  // Values after reset, and the broadcast node address
  localparam logic [7:0]  RST_SEC_REMOVAL = 8'h3B;
  localparam logic [7:0]  RST_PSA_EN      = 8'h01;
  localparam logic [7:0]  RST_INIT_TMO    = 8'h0A;
  localparam logic [15:0] RST_NODE        = 16'h0001;
  localparam logic [15:0] RST_DRV         = 16'h0404;
  localparam logic [15:0] NODE_BROADCAST  = 16'h0000;
  localparam logic [31:0] MAX_PRELOAD_DEF = 32'h0000_0000;

  // Writable bit masks of mixed registers
  localparam logic [7:0] WM_SEC_REMOVAL = 8'h30;
  localparam logic [7:0] WM_PSA_EN      = 8'h03;
  localparam logic [7:0] WM_BIT0        = 8'h01;
  localparam logic [7:0] WM_FULL        = 8'hFF;

  // Controller register offsets (AXI4-Lite byte addresses)
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_NODE   = 8'h04;
  localparam logic [7:0] OFF_DATA   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_RDATA  = 8'h10;

  // Controller wait for an answer, in cycles
  localparam logic [7:0] RSP_TIMEOUT_CYC = 8'h10;

endpackage : ecsd_pkg

// *** src/ecsd_link_if.sv ***
// Command link between the controller and the configuration bank
`timescale 1ns/1ps
interface ecsd_link_if;
  logic                    cmdValid;
  ecsd_pkg::ecsd_op_t      cmdOp;
  logic [15:0]             cmdNode;
  logic [7:0]              cmdIndex;
  logic [15:0]             cmdData;
  logic                    rspValid;
  logic [15:0]             rspData;

  modport dev  (input cmdValid, cmdOp, cmdNode, cmdIndex, cmdData, output rspValid, rspData);
  modport host (output cmdValid, cmdOp, cmdNode, cmdIndex, cmdData, input rspValid, rspData);
endinterface : ecsd_link_if

// *** src/ecsd_device.sv ***
// Configuration byte bank with node address and driver stage registers
// What this block does
// - Reserved configuration bits always read zero
// - Obsolete field values have no effect
// - Writable 16-bit node address set by host
// - Answer only commands carrying own node address, plus every nonzero node assignment
// - Node address resets to 0x0001
// - Address zero never assigned; selects all to stand-by
// - Driver stage resets to 0x404, kept until programmed
// - Driver stage support reported; programmed only if supported
`timescale 1ns/1ps
module ecsd_device #(
  parameter logic [31:0] MaxPreload     = ecsd_pkg::MAX_PRELOAD_DEF,
  parameter bit          DrvImplemented = 1'b1
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Link to the controller
  ecsd_link_if.dev                  link,
  // Status fed by the device core
  input  wire logic [7:0]           ffuResult,
  input  wire logic [7:0]           packedResult,
  input  wire logic [7:0]           packedFailIndex,
  input  wire logic [15:0]          exceptionFlags,
  input  wire logic [7:0]           groupsToRelease,
  input  wire logic [7:0]           dataBlockSize,
  // Settings seen by the device core
  output logic [15:0]               nodeAddress,
  output logic [15:0]               driverStage,
  output logic                      selected,
  output logic                      cacheOn,
  output logic                      cmdqOn,
  output logic                      barrierOn,
  output logic                      cacheFlushPulse,
  output logic                      modeOpPulse,
  output logic [7:0]                modeOpCode
);
  import ecsd_pkg::*;

  logic [7:0]  cfg_r [IDX_LO:IDX_HI];
  logic [15:0] node_r;
  logic [15:0] drv_r;
  logic        selected_r;
  logic        rspValid_r;
  logic [15:0] rspData_r;
  logic        flush_r;
  logic        modeOp_r;
  logic [7:0]  modeCode_r;
  logic        addrHit;
  logic [7:0]  rdByte;

  // Reset value of each stored byte
  function automatic logic [7:0] resetByte(input int idx);
    if (idx == int'(IDX_SEC_REMOVAL))
      resetByte = RST_SEC_REMOVAL;
    else if (idx == int'(IDX_PSA_EN))
      resetByte = RST_PSA_EN;
    else
      resetByte = 8'h00;
  endfunction : resetByte

  // Bits the host may change in each byte
  function automatic logic [7:0] writeMask(input logic [7:0] idx);
    if (idx == IDX_CMDQ || idx == IDX_BARRIER || idx == IDX_CACHE || idx == IDX_EMULATION)
      writeMask = WM_BIT0;
    else if (idx == IDX_SEC_REMOVAL)
      writeMask = WM_SEC_REMOVAL;
    else if (idx == IDX_PSA_EN)
      writeMask = WM_PSA_EN;
    else if ((idx >= IDX_PRELOAD && idx < IDX_FFU_RESULT) || idx == IDX_MODE_SEL
             || idx == IDX_SHUTDOWN || idx == IDX_CLASS6)
      writeMask = WM_FULL;
    else if (idx >= IDX_CONTEXT && idx < IDX_EXC_FLAGS)
      writeMask = WM_FULL;
    else if (idx == IDX_EXC_MASK || idx == IDX_EXC_MASK + 8'h01)
      writeMask = WM_FULL;
    else
      writeMask = 8'h00;
  endfunction : writeMask

  // Command carries this node's own address
  assign addrHit = link.cmdValid && (link.cmdNode == node_r);

  // Read view of the byte array
  always_comb
  begin
    rdByte = 8'h00;
    if (link.cmdIndex >= IDX_MAX_PRELOAD && link.cmdIndex < IDX_PRELOAD)
      rdByte = MaxPreload[8 * (link.cmdIndex - IDX_MAX_PRELOAD) +: 8];
    else if (link.cmdIndex == IDX_FFU_RESULT)
      rdByte = ffuResult;
    else if (link.cmdIndex == IDX_PACK_FAIL)
      rdByte = packedFailIndex;
    else if (link.cmdIndex == IDX_PACK_RESULT)
      rdByte = packedResult;
    else if (link.cmdIndex == IDX_EXC_FLAGS)
      rdByte = exceptionFlags[7:0];
    else if (link.cmdIndex == IDX_EXC_FLAGS + 8'h01)
      rdByte = exceptionFlags[15:8];
    else if (link.cmdIndex == IDX_GROUPS_REL)
      rdByte = groupsToRelease;
    else if (link.cmdIndex == IDX_INIT_TMO)
      rdByte = RST_INIT_TMO;
    else if (link.cmdIndex == IDX_BLK_SIZE)
      rdByte = dataBlockSize;
    else if (link.cmdIndex >= IDX_LO && link.cmdIndex <= IDX_HI)
      rdByte = cfg_r[link.cmdIndex];
  end

  // Configuration byte storage, masked writes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = int'(IDX_LO); i <= int'(IDX_HI); i++)
        cfg_r[i] <= resetByte(i);
    end
    else if (addrHit && link.cmdOp == ECSD_OP_WRITE && writeMask(link.cmdIndex) != 8'h00)
    begin
      // Bits outside the mask are ignored as don't-care
      cfg_r[link.cmdIndex] <= (cfg_r[link.cmdIndex] & ~writeMask(link.cmdIndex))
                            | (link.cmdData[7:0] & writeMask(link.cmdIndex));
    end
  end

  // Node address, assigned during identification
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      node_r <= RST_NODE;
    else if (link.cmdValid && link.cmdOp == ECSD_OP_SET_NODE
             && link.cmdData != NODE_BROADCAST)
      node_r <= link.cmdData;
  end

  // Driver stage, only if implemented
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      drv_r <= RST_DRV;
    else if (addrHit && link.cmdOp == ECSD_OP_SET_DRV && DrvImplemented)
      drv_r <= link.cmdData;
  end

  // Selection state
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      selected_r <= 1'b0;
    else if (link.cmdValid && link.cmdOp == ECSD_OP_SELECT)
      selected_r <= (link.cmdNode == node_r) && (link.cmdNode != NODE_BROADCAST);
  end

  // Answers to the controller
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rspValid_r <= 1'b0;
      rspData_r  <= 16'h0000;
    end
    else
    begin
      rspValid_r <= 1'b0;
      rspData_r  <= 16'h0000;
      if (link.cmdValid && link.cmdOp == ECSD_OP_SET_NODE && link.cmdData != NODE_BROADCAST)
      begin
        rspValid_r <= 1'b1;
        rspData_r  <= link.cmdData;
      end
      else if (addrHit && link.cmdNode != NODE_BROADCAST)
      begin
        rspValid_r <= 1'b1;
        case (link.cmdOp)
          ECSD_OP_SELECT:   rspData_r <= node_r;
          ECSD_OP_READ:     rspData_r <= {8'h00, rdByte};
          ECSD_OP_WRITE:    rspData_r <= {8'h00, link.cmdData[7:0] & writeMask(link.cmdIndex)};
          ECSD_OP_SET_DRV:  rspData_r <= DrvImplemented ? link.cmdData : RST_DRV;
          ECSD_OP_GET_CAPS: rspData_r <= {15'h0000, DrvImplemented};
          default:          rspData_r <= 16'h0000;
        endcase
      end
    end
  end

  // Side effects of write-only triggers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      flush_r    <= 1'b0;
      modeOp_r   <= 1'b0;
      modeCode_r <= 8'h00;
    end
    else
    begin
      // Only bit 0 starts a flush; other values do nothing
      flush_r  <= addrHit && link.cmdOp == ECSD_OP_WRITE
                  && link.cmdIndex == IDX_FLUSH && link.cmdData[0];
      modeOp_r <= addrHit && link.cmdOp == ECSD_OP_WRITE && link.cmdIndex == IDX_MODE_OP;
      if (addrHit && link.cmdOp == ECSD_OP_WRITE && link.cmdIndex == IDX_MODE_OP)
        modeCode_r <= link.cmdData[7:0];
    end
  end

  // Outputs straight from flops
  assign link.rspValid   = rspValid_r;
  assign link.rspData    = rspData_r;
  assign nodeAddress     = node_r;
  assign driverStage     = drv_r;
  assign selected        = selected_r;
  assign cacheOn         = cfg_r[IDX_CACHE][0];
  assign cmdqOn          = cfg_r[IDX_CMDQ][0];
  assign barrierOn       = cfg_r[IDX_BARRIER][0];
  assign cacheFlushPulse = flush_r;
  assign modeOpPulse     = modeOp_r;
  assign modeOpCode      = modeCode_r;

endmodule : ecsd_device

// *** sim/ecsd_link_checker.sv ***
// Link protocol checker for the controller-to-bank command link
`timescale 1ns/1ps
module ecsd_link_checker
  import ecsd_pkg::*;
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // Link signals
  input wire logic               cmdValid,
  input wire ecsd_pkg::ecsd_op_t cmdOp,
  input wire logic [15:0]        cmdNode,
  input wire logic [7:0]         cmdIndex,
  input wire logic [15:0]        cmdData,
  input wire logic               rspValid,
  input wire logic [15:0]        rspData
);
  import ecsd_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [15:0] nodeTrack_r;
  logic        capsSeen_r;
  logic        capsAsk_r;
  wire         addressed = cmdValid && cmdOp != ECSD_OP_SET_NODE;
  wire         ownNode   = cmdNode == nodeTrack_r && cmdNode != NODE_BROADCAST;
  wire         resvIdx   = cmdIndex < IDX_LO || cmdIndex > IDX_HI ||
                           cmdIndex == 8'h1B || cmdIndex == 8'h1C;

  // Shadow of the bank's node address
  always_ff @(posedge clk)
    if (!rst_n) nodeTrack_r <= RST_NODE;
    else if (cmdValid && cmdOp == ECSD_OP_SET_NODE && cmdData != NODE_BROADCAST)
      nodeTrack_r <= cmdData;

  // Remembers a capability answer that reported driver stage support
  always_ff @(posedge clk)
    if (!rst_n) capsAsk_r <= 1'b0;
    else capsAsk_r <= cmdValid && cmdOp == ECSD_OP_GET_CAPS;

  always_ff @(posedge clk)
    if (!rst_n) capsSeen_r <= 1'b0;
    else if (rspValid && capsAsk_r && rspData[0]) capsSeen_r <= 1'b1;

  resp_after_cmd_a: assert property (rspValid |-> $past(cmdValid))
    else $error("answer without a command");
  cmd_single_pulse_a: assert property (cmdValid |=> !cmdValid)
    else $error("command strobe longer than one cycle");
  own_node_answer_a: assert property (addressed && ownNode |=> rspValid)
    else $error("own node command not answered");
  foreign_node_quiet_a: assert property (addressed && !ownNode |=> !rspValid)
    else $error("foreign or zero node command answered");
  node_assign_echo_a: assert property (
    cmdValid && cmdOp == ECSD_OP_SET_NODE |=> rspValid && rspData == $past(cmdData))
    else $error("node assignment not echoed");
  no_zero_assign_a: assert property (
    cmdValid && cmdOp == ECSD_OP_SET_NODE |-> cmdData != NODE_BROADCAST)
    else $error("zero node address assigned");
  reserved_zero_a: assert property (
    cmdValid && cmdOp == ECSD_OP_READ && ownNode && resvIdx |=> rspData == 16'h0000)
    else $error("reserved byte read nonzero");
  read_upper_zero_a: assert property (
    cmdValid && cmdOp == ECSD_OP_READ && ownNode |=> rspData[15:8] == 8'h00)
    else $error("read answer upper byte nonzero");
  drv_after_caps_a: assert property (cmdValid && cmdOp == ECSD_OP_SET_DRV |-> capsSeen_r)
    else $error("driver stage set before support known");

  // Main scenarios
  cover property (cmdValid && cmdOp == ECSD_OP_SET_NODE);
  cover property (cmdValid && cmdOp == ECSD_OP_SELECT && cmdNode == NODE_BROADCAST);
  cover property (addressed && !ownNode && cmdNode != NODE_BROADCAST);
  cover property (cmdValid && cmdOp == ECSD_OP_SET_DRV ##1 rspValid);
endmodule : ecsd_link_checker

// *** sim/tb.sv ***
// Register-level testbench for controller and configuration bank
`timescale 1ns/1ps
module tb;
  import ecsd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] ffu = 8'hA5, pres = 8'h3C, pfail = 8'h07, grp = 8'h11, blk = 8'h01;
  logic [15:0] exc = 16'hBEEF;
  logic [15:0] nodeAddress, driverStage;
  logic selected, cacheOn, cmdqOn, barrierOn, flushPulse, modeOpPulse;
  logic [7:0] modeOpCode;
  int n_mismatch = 0, comparisons = 0, flushCount = 0, modeCount = 0;
  logic [1:0] r;
  logic [31:0] st, v;
  // Reset-value and status byte table
  logic [7:0] ridx [19] = '{8'h00, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h15, 8'h1A, 8'h1B,
    8'h1D, 8'h23, 8'h24, 8'h36, 8'h37, 8'h3A, 8'h3C, 8'h3D, 8'h3F, 8'h25};
  logic [7:0] rexp [19] = '{8'h00, 8'h00, 8'h00, 8'h3B, 8'h01, 8'h78, 8'h12, 8'hA5, 8'h00,
    8'h00, 8'h07, 8'h3C, 8'hEF, 8'hBE, 8'h11, 8'h0A, 8'h01, 8'h00, 8'h00};
  // Write table: index, written byte, byte read back
  logic [7:0] widx [13] = '{8'h10, 8'h10, 8'h11, 8'h21, 8'h0F, 8'h1F, 8'h20, 8'h1D, 8'h22,
    8'h3B, 8'h3E, 8'h16, 8'h33};
  logic [7:0] wval [13] = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'h01, 8'h07, 8'h5A,
    8'hC3, 8'hFE, 8'h9C, 8'h77};
  logic [7:0] wexp [13] = '{8'h3B, 8'h0B, 8'h03, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h5A,
    8'hC3, 8'h00, 8'h9C, 8'h77};

  always #12.5 clk = ~clk;

  ecsd_link_if link ();

  ecsd_device #(.MaxPreload(32'h1234_5678), .DrvImplemented(1'b1)) u_ecsd_device (
    .clk(clk), .rst_n(rst_n), .link(link.dev),
    .ffuResult(ffu), .packedResult(pres), .packedFailIndex(pfail), .exceptionFlags(exc),
    .groupsToRelease(grp), .dataBlockSize(blk),
    .nodeAddress(nodeAddress), .driverStage(driverStage), .selected(selected),
    .cacheOn(cacheOn), .cmdqOn(cmdqOn), .barrierOn(barrierOn),
    .cacheFlushPulse(flushPulse), .modeOpPulse(modeOpPulse), .modeOpCode(modeOpCode));

  ecsd_host u_ecsd_host (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link(link.host));

  ecsd_link_checker u_ecsd_link_checker (
    .clk(clk), .rst_n(rst_n), .cmdValid(link.cmdValid), .cmdOp(link.cmdOp),
    .cmdNode(link.cmdNode), .cmdIndex(link.cmdIndex), .cmdData(link.cmdData),
    .rspValid(link.rspValid), .rspData(link.rspData));

  // Counts one-cycle strobes towards the device core
  always @(posedge clk)
  begin
    if (flushPulse === 1'b1) flushCount++;
    if (modeOpPulse === 1'b1) modeCount++;
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    bit awDone, wDone;
    int n;
    awDone = 0;
    wDone = 0;
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (!awDone && awready === 1'b1) begin awDone = 1; awvalid <= 1'b0; end
      if (!wDone && wready === 1'b1) begin wDone = 1; wvalid <= 1'b0; end
      if (bvalid === 1'b1) begin resp = bresp; bready <= 1'b0; break; end
    end
    check("write answer", n < 100, 1);
    if (n == 100) give_verdict();
  endtask : axi_write

  task axi_read(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin d = rdata; rready <= 1'b0; break; end
    end
    check("read answer", n < 100, 1);
    if (n == 100) give_verdict();
  endtask : axi_read

  // Launches one link command and polls until the controller reports done
  task run_cmd(input ecsd_op_t op, input logic [7:0] idx, input logic [15:0] d,
               output logic [31:0] s);
    int n;
    axi_write(OFF_DATA, {16'h0, d}, r);
    axi_write(OFF_CTRL, {16'h0, idx, 5'h0, op}, r);
    for (n = 0; n < 40; n++)
    begin
      axi_read(OFF_STATUS, s);
      if (s[1] === 1'b1 && s[0] === 1'b0) break;
    end
    check("command done", n < 40, 1);
    if (n == 40) give_verdict();
  endtask : run_cmd

  task rd_byte(input logic [7:0] idx, input logic [7:0] exp);
    run_cmd(ECSD_OP_READ, idx, 16'h0, st);
    axi_read(OFF_RDATA, v);
    check($sformatf("byte %h", idx), v, {24'h0, exp});
  endtask : rd_byte

  task give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("node after reset", nodeAddress, 16'h0001);
    check("stage after reset", driverStage, 16'h0404);
    axi_write(8'h40, 32'h0, r);
    check("unmapped bresp", r, 2'h2);
    axi_read(8'h44, v);
    check("unmapped rresp", rresp, 2'h2);
    run_cmd(ECSD_OP_SET_DRV, 8'h00, 16'h0ABC, st);
    check("early stage refused", st[3], 1'b1);
    check("stage kept", driverStage, 16'h0404);
    run_cmd(ECSD_OP_GET_CAPS, 8'h00, 16'h0, st);
    check("stage supported", st[4], 1'b1);
    run_cmd(ECSD_OP_SET_DRV, 8'h00, 16'h0ABC, st);
    check("stage programmed", driverStage, 16'h0ABC);
    for (int i = 0; i < 19; i++) rd_byte(ridx[i], rexp[i]);
    for (int i = 0; i < 13; i++)
    begin
      run_cmd(ECSD_OP_WRITE, widx[i], {8'h00, wval[i]}, st);
      rd_byte(widx[i], wexp[i]);
    end
    check("cache on", {cacheOn, cmdqOn, barrierOn}, 3'b111);
    check("mode code", modeOpCode, 8'h07);
    check("pulses", {flushCount[3:0], modeCount[3:0]}, 8'h11);
    run_cmd(ECSD_OP_SET_NODE, 8'h00, 16'h0000, st);
    check("zero node refused", st[3], 1'b1);
    check("node kept", nodeAddress, 16'h0001);
    run_cmd(ECSD_OP_SET_NODE, 8'h00, 16'h1234, st);
    check("node set", nodeAddress, 16'h1234);
    axi_read(OFF_RDATA, v);
    check("node echo", v[15:0], 16'h1234);
    run_cmd(ECSD_OP_READ, 8'h10, 16'h0, st);
    check("old node quiet", st[2], 1'b1);
    axi_write(OFF_NODE, 32'h1234, r);
    run_cmd(ECSD_OP_SELECT, 8'h00, 16'h0, st);
    check("selected", {selected, st[2]}, 2'b10);
    axi_write(OFF_NODE, 32'h0, r);
    run_cmd(ECSD_OP_SELECT, 8'h00, 16'h0, st);
    check("stand-by", {selected, st[2]}, 2'b01);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("node again", nodeAddress, 16'h0001);
    check("stage again", driverStage, 16'h0404);
    rd_byte(8'h10, 8'h3B);
    give_verdict();
  end
endmodule : tb
